// [core/qpio_ports.sv]
// quad parallel i/o ports with wishbone register access
`timescale 1ns/1ps
`include "qpio_params.svh"
module qpio_ports (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire qpio_pkg::qpio_ext_t ext_i,
  input wire qpio_pkg::qpio_alt_out_t alt_i,
  output qpio_pkg::qpio_alt_in_t alt_o,
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_digital_in,
  input wire logic [7:0] p2_in,
  output logic [7:0] p2_out,
  output logic [7:0] p2_oe,
  input wire logic [7:0] p3_in,
  output logic [7:0] p3_out,
  output logic [7:0] p3_oe
);
  import qpio_pkg::*;

  // ----------------------------------------
  // latches
  // ----------------------------------------
  logic [7:0] port0_output_latch;
  logic [7:0] port1_input_config;
  logic [7:0] port2_output_latch;
  logic [7:0] port3_output_latch;
  logic wb_req;
  logic [7:0] next_p0_out;
  logic [7:0] next_p0_oe;
  logic [7:0] next_p3_drv;
  logic [7:0] next_p3_oe;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d, input logic [3:0] sel);
    merge_byte = sel[0] ? d[7:0] : old;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port0_output_latch <= `QPIO_RESET_LATCH; // RQ14
      port1_input_config <= `QPIO_RESET_LATCH; // RQ6
      port2_output_latch <= `QPIO_RESET_LATCH; // RQ14
      port3_output_latch <= `QPIO_RESET_LATCH; // RQ14
    end else if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        `QPIO_ADDR_P0: port0_output_latch <= merge_byte(port0_output_latch, wb_dat_i, wb_sel_i); // RQ1
        `QPIO_ADDR_P1: port1_input_config <= merge_byte(port1_input_config, wb_dat_i, wb_sel_i); // RQ6
        `QPIO_ADDR_P2: port2_output_latch <= merge_byte(port2_output_latch, wb_dat_i, wb_sel_i); // RQ8
        `QPIO_ADDR_P3: port3_output_latch <= merge_byte(port3_output_latch, wb_dat_i, wb_sel_i); // RQ10
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `QPIO_ADDR_P0: wb_dat_o <= {24'h0, p0_in};
          `QPIO_ADDR_P1: wb_dat_o <= {24'h0, p1_in}; // RQ5
          `QPIO_ADDR_P2: wb_dat_o <= {24'h0, p2_in}; // RQ8
          `QPIO_ADDR_P3: wb_dat_o <= {24'h0, p3_in}; // RQ10
          default: wb_dat_o <= 32'h0;
        endcase
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end

  // ----------------------------------------
  // port 0 open drain / external bus
  // ----------------------------------------
  always_comb begin
    if (ext_i.bus_active) begin
      next_p0_out = ext_i.addr_phase ? ext_i.addr_lo : ext_i.wdata; // RQ3
      next_p0_oe = (ext_i.addr_phase || ext_i.data_out) ? 8'hff : 8'h00; // RQ4
    end else begin
      next_p0_out = 8'h00;
      next_p0_oe = ~port0_output_latch; // RQ1 RQ2
    end
  end

  // ----------------------------------------
  // port 3 alternate outputs
  // ----------------------------------------
  always_comb begin
    next_p3_drv = port3_output_latch;
    next_p3_drv[0] = port3_output_latch[0] & (alt_i.rxd_oe ? alt_i.rxd_out : 1'b1); // RQ11 RQ12
    next_p3_drv[1] = port3_output_latch[1] & alt_i.txd; // RQ11 RQ12
    next_p3_drv[6] = port3_output_latch[6] & alt_i.wr_n; // RQ11 RQ12
    next_p3_drv[7] = port3_output_latch[7] & alt_i.rd_n; // RQ11 RQ12
    next_p3_oe = ~next_p3_drv; // RQ10
  end

  // ----------------------------------------
  // registered pin outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      p0_out <= 8'h00;
      p0_oe <= 8'h00;
      p2_out <= 8'hff;
      p2_oe <= 8'h00;
      p3_out <= 8'hff;
      p3_oe <= 8'h00;
      p1_digital_in <= 8'h00;
    end else begin
      p0_out <= next_p0_out;
      p0_oe <= next_p0_oe;
      p2_out <= ext_i.bus_active ? ext_i.addr_hi : port2_output_latch; // RQ9
      p2_oe <= ext_i.bus_active ? 8'hff : ~port2_output_latch; // RQ8 RQ9
      p3_out <= next_p3_drv;
      p3_oe <= next_p3_oe;
      p1_digital_in <= ~port1_input_config; // RQ5 RQ6
    end
  end

  // ----------------------------------------
  // alternate inputs gated by latch
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alt_o <= '0;
    end else begin
      alt_o.timer2_count_input <= p1_in[`QPIO_ALT_P1_T2] & port1_input_config[`QPIO_ALT_P1_T2]; // RQ7 RQ12
      alt_o.timer2_capture_trigger <= p1_in[`QPIO_ALT_P1_TIMER2_CAPTURE_TRIGGER] & port1_input_config[`QPIO_ALT_P1_TIMER2_CAPTURE_TRIGGER]; // RQ7 RQ12
      alt_o.spi_select_n <= p1_in[`QPIO_ALT_P1_SS] & port1_input_config[`QPIO_ALT_P1_SS]; // RQ7 RQ12
      alt_o.rxd <= p3_in[0] & port3_output_latch[0]; // RQ11 RQ12
      alt_o.external_irq_zero <= p3_in[2] & port3_output_latch[2]; // RQ11 RQ12
      alt_o.external_irq_one <= p3_in[3] & port3_output_latch[3]; // RQ11 RQ12
      alt_o.timer0_count_input <= p3_in[4] & port3_output_latch[4]; // RQ11 RQ12
      alt_o.timer1_count_input <= p3_in[5] & port3_output_latch[5]; // RQ11 RQ12
    end
  end
endmodule

// [shared/qpio_params.svh]
// constants for the quad parallel i/o ports
// Summary of operation
// [RQ1] port 0: eight open-drain pins driven from latch at address 80h
// [RQ2] port 0 latch one leaves pin floating, usable as input
// [RQ3] port 0 carries low address and data during external accesses
// [RQ4] port 0 drives ones strongly while acting as external bus
// [RQ5] port 1 at address 90h is input only, never driven
// [RQ6] port 1 bits reset to one (analog); zero selects digital input
// [RQ7] port 1 pins 0,1,5: timer2 count, timer2 trigger, slave select
// [RQ8] port 2 at a0h bidirectional with pull-ups; ones read as inputs
// [RQ9] port 2 drives high address bytes during external accesses
// [RQ10] port 3 at b0h bidirectional with pull-ups; ones usable as inputs
// [RQ11] port 3 pins carry uart, interrupts, timers, write and read strobes
// [RQ12] alternate functions work only with latch one, else pin held zero
// [RQ13] software avoids general use of pins owned by enabled peripherals
// [RQ14] latches of ports 0, 2, 3 reset to all ones
`ifndef QPIO_PARAMS_SVH
`define QPIO_PARAMS_SVH
`define QPIO_ADDR_P0 8'h80
`define QPIO_ADDR_P1 8'h90
`define QPIO_ADDR_P2 8'ha0
`define QPIO_ADDR_P3 8'hb0
`define QPIO_RESET_LATCH 8'hff
`define QPIO_ALT_P1_T2 0
`define QPIO_ALT_P1_TIMER2_CAPTURE_TRIGGER 1
`define QPIO_ALT_P1_SS 5
`endif

// [shared/qpio_pkg.sv]
// types for the quad parallel i/o ports
package qpio_pkg;
  typedef struct packed {
    logic [7:0] din;
    logic [7:0] dout;
    logic [7:0] oe;
  } qpio_pins_t;
  typedef struct packed {
    logic bus_active;
    logic addr_phase;
    logic [7:0] addr_lo;
    logic [7:0] wdata;
    logic data_out;
    logic [7:0] addr_hi;
  } qpio_ext_t;
  typedef struct packed {
    logic txd;
    logic rxd_out;
    logic rxd_oe;
    logic wr_n;
    logic rd_n;
  } qpio_alt_out_t;
  typedef struct packed {
    logic timer2_count_input;
    logic timer2_capture_trigger;
    logic spi_select_n;
    logic rxd;
    logic external_irq_zero;
    logic external_irq_one;
    logic timer0_count_input;
    logic timer1_count_input;
  } qpio_alt_in_t;
endpackage

// [tb/qpio_board.sv]
// board model: pull-ups and external drivers on the port pins
`timescale 1ns/1ps
module qpio_board (
  input wire logic [23:0] drv_out,
  input wire logic [23:0] drv_oe,
  input wire logic [23:0] ext_drive,
  output logic [23:0] pin_level
);
  // pull-ups where undriven, wired-and with board drivers
  assign pin_level = (drv_oe & drv_out | ~drv_oe) & ext_drive;
endmodule

// [tb/qpio_ports_chk.sv]
// port timing and level checker
`timescale 1ns/1ps
module qpio_ports_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire qpio_pkg::qpio_ext_t ext_i,
  input wire qpio_pkg::qpio_alt_out_t alt_i,
  input wire qpio_pkg::qpio_alt_in_t alt_o,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p2_oe,
  input wire logic [7:0] p3_out,
  input wire logic [7:0] p3_oe
);
  import qpio_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rst_vals: assert property ($rose(rst_n) |-> p2_out == 8'hff && p3_out == 8'hff && p0_oe == 8'h00)
    else $error("bad reset state");
  a_p0_drain: assert property (!ext_i.bus_active |=> p0_out == 8'h00) else $error("p0 drives high");
  a_p0_addr: assert property (ext_i.bus_active && ext_i.addr_phase |=>
    p0_out == $past(ext_i.addr_lo) && p0_oe == 8'hff) else $error("p0 address wrong");
  a_p2_addr: assert property (ext_i.bus_active |=> p2_out == $past(ext_i.addr_hi) && p2_oe == 8'hff)
    else $error("p2 address wrong");
  a_p2_pull: assert property (!ext_i.bus_active |=> p2_oe == ~p2_out) else $error("p2 drive wrong");
  a_p3_weak: assert property (p3_oe == ~p3_out) else $error("p3 drive wrong");
  a_p3_strobe: assert property (!alt_i.wr_n |=> !p3_out[6]) else $error("p3 strobe lost");
  a_p3_gate: assert property (!p3_out[2] |-> !alt_o.external_irq_zero) else $error("p3 gate open");
  cover property (ext_i.bus_active && ext_i.data_out);
  cover property (!alt_i.wr_n);
  cover property (alt_o.timer0_count_input);
endmodule
bind qpio_ports qpio_ports_chk qpio_ports_chk_inst (.*);

// [tb/tb_qpio_ports.sv]
// testbench for the quad parallel i/o ports
`timescale 1ns/1ps
module tb_qpio_ports;
  import qpio_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00, p1_in = 8'hff, p0_out, p0_oe, p1_dig, p2_out, p2_oe, p3_out, p3_oe;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, q, rdat;
  logic [23:0] ext_drive = 24'hffffff, pins;
  qpio_ext_t ext = '0;
  qpio_alt_out_t alt = '1;
  qpio_alt_in_t alt_o;
  int fails = 0, cmp_count = 0;
  initial forever #5 clk = ~clk;
  qpio_ports qpio_ports_inst (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .ext_i(ext), .alt_i(alt), .alt_o,
    .p0_in(pins[7:0]), .p0_out, .p0_oe, .p1_in, .p1_digital_in(p1_dig), .p2_in(pins[15:8]), .p2_out,
    .p2_oe, .p3_in(pins[23:16]), .p3_out, .p3_oe);
  qpio_board qpio_board_inst (.drv_out({p3_out, p2_out, p0_out}), .drv_oe({p3_oe, p2_oe, p0_oe}),
    .ext_drive, .pin_level(pins));
  task complete_run;
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) fails++;
    if (seen !== exp) $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = q;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
    if (n >= 20) fails++;
    if (n >= 20) complete_run();
  endtask
  task settle; repeat (3) @(posedge clk); endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk({p0_oe, p2_oe, p3_oe, p1_dig}, 32'h00000000);
    chk({24'h000000, p2_out & p3_out}, 32'h000000ff);
    wb(1'b0, 8'h80, 4'h1, 32'h0);
    chk(rdat, 32'hff);
    wb(1'b1, 8'h80, 4'h1, 32'h5a);
    wb(1'b1, 8'h80, 4'h0, 32'h00);
    settle();
    chk({p0_oe, p0_out}, 16'ha500);
    wb(1'b1, 8'h90, 4'h1, 32'hde);
    settle();
    chk(p1_dig, 8'h21);
    chk({alt_o.timer2_count_input, alt_o.timer2_capture_trigger, alt_o.spi_select_n}, 3'b010);
    alt.wr_n <= 1'b0;
    wb(1'b1, 8'hb0, 4'h1, 32'hf3);
    settle();
    chk({p3_oe, p3_out}, 16'h4cb3);
    chk({alt_o.external_irq_zero, alt_o.timer0_count_input, alt_o.rxd}, 3'b011);
    wb(1'b1, 8'ha0, 4'h1, 32'h0f);
    wb(1'b1, 8'h44, 4'h1, 32'hff);
    wb(1'b0, 8'h44, 4'h1, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b0, 8'ha0, 4'h1, 32'h0);
    chk({rdat[7:0], p2_oe, p2_out}, 24'h0ff00f);
    ext <= {1'b1, 1'b1, 8'h3c, 8'hc3, 1'b0, 8'h12};
    settle();
    chk({p0_oe, p0_out, p2_oe, p2_out}, 32'hff3cff12);
    ext <= {1'b1, 1'b0, 8'h3c, 8'hc3, 1'b1, 8'h12};
    settle();
    chk({p0_oe, p0_out}, 16'hffc3);
    ext <= '0;
    ext_drive[7:0] <= 8'h0f;
    settle();
    wb(1'b0, 8'h80, 4'h1, 32'h0);
    chk(rdat, 32'h0a);
    complete_run();
  end
endmodule
